// File: core/bpc_pkg.sv
// package for the byte parity controller: register map, layouts, timing, types
package bpc_pkg;

  // ============================================================
  // register map (byte addresses, one 32-bit word each)
  localparam logic [11:0] CSR_OFFSET    = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam int          ADDR_W        = 12;

  // ============================================================
  // control/status word layout
  localparam int          CSR_ERR_EN_BIT   = 0;
  localparam int          CSR_WRONG_BIT    = 2;
  localparam int          CSR_ADDR_LSB     = 5;
  localparam int          CSR_ADDR_W       = 7;
  localparam int          CSR_PAR_ERR_BIT  = 15;
  localparam logic [15:0] CSR_WMASK        = 16'h8fe5;
  localparam logic [15:0] CSR_RST          = 16'h0000;

  // status word layout (live state, read only)
  localparam int          STS_ERR_FF_BIT   = 0;
  localparam int          STS_INH_FF_BIT   = 1;
  localparam int          STS_FSM_LSB      = 2;
  localparam int          STS_PAR_ERR_BIT  = 6;
  localparam int          STS_ODD_LSB      = 7;

  // ============================================================
  // timing, clock 40 MHz
  localparam int          CLK_PERIOD_NS    = 25;
  localparam int          SAMPLE_DELAY_NS  = 110;
  localparam int          PULSE_MIN_NS     = 25;
  localparam int          SAMPLE_CYC       = SAMPLE_DELAY_NS / CLK_PERIOD_NS;
  localparam int          PULSE_CYC        = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W            = 3;
  localparam logic [CNT_W-1:0] SAMPLE_CNT_INIT = CNT_W'(SAMPLE_CYC - 1);
  localparam logic [CNT_W-1:0] PULSE_CNT_INIT  = CNT_W'(PULSE_CYC - 1);

  // ============================================================
  // types
  typedef enum logic [3:0] {
    BPC_IDLE      = 4'b0001,
    BPC_SAMPLE    = 4'b0010,
    BPC_ERR_PULSE = 4'b0100,
    BPC_HOLD      = 4'b1000
  } bpc_fsm_t;

  typedef enum logic [1:0] {
    BPC_REG_NONE   = 2'h0,
    BPC_REG_CSR    = 2'h1,
    BPC_REG_STATUS = 2'h2
  } bpc_reg_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } bpc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } bpc_apb_rsp_t;

  // backplane inputs, all asynchronous to SYS_CLK
  typedef struct packed {
    logic [15:0]           data;
    logic [CSR_ADDR_W-1:0] addr_hi;
    logic [1:0]            mem_par_n;
    logic                  write_cycle_indicator_n;
    logic                  bus_master_sync;
    logic                  memory_slave_sync;
    logic                  bus_init;
  } bpc_pins_t;

endpackage

// File: core/bpc_top.sv
// byte parity controller: parity gen/check, error sampling, slave sync control
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Summary of operation
// - generate on writes, check on reads
// - low byte owns bit 0, high bit 1
// - odd output high for odd ones count
// - correct write: ninth inputs high, odd parity
// - wrong-parity bit set: inverted parity written
// - read: inverted stored parity feeds ninth input
// - write: drive parity active low to memory
// - read: memory parity drivers stay off
// - error when either odd output low
// - sample error about 110 ns after sync
// - no sampling during write cycles
// - error sets flag bit 15, LED
// - error captures address high bits 5-11
// - parity error line only if enabled
// - error delays slave sync one extra pulse
// - slave sync = memory sync and not inhibit
// - master sync assertion presets inhibit
// - error pulse end clears inhibit
// - clean read leaves inhibit cleared at sample
// - write cycle holds inhibit cleared
// - bus init clears bits 0, 2, 15
module bpc_top
  import bpc_pkg::*;
(
  input  wire logic                  SYS_CLK,          // 40 MHz clock
  input  wire logic                  NRST,             // async reset, active low
  input  wire bpc_pkg::bpc_apb_req_t APB_REQ,          // apb request
  output var bpc_pkg::bpc_apb_rsp_t  APB_RSP,          // apb response
  input  wire bpc_pkg::bpc_pins_t    BUS_IN,           // backplane inputs
  output logic                       BUS_SLAVE_SYNC,   // slave sync to master, high
  output logic                       BUS_PARITY_ERROR, // parity error line, high
  output logic                       ERROR_LED,        // error indicator
  output logic [1:0]                 MEM_PARITY_OUT_N, // parity to memory, low = one
  output logic [1:0]                 MEM_PARITY_OE_N   // driver enable, low = drive
);
  import bpc_pkg::*;

  // ============================================================
  // state
  typedef struct packed {
    bpc_pins_t             s1;
    bpc_pins_t             s2;
    logic                  msync_prev;
    bpc_fsm_t              fsm;
    logic [CNT_W-1:0]      cnt;
    logic                  err_ff;
    logic                  inh_ff;
    logic [15:0]           control_status_word;
    logic [1:0]            par_out_n;
    logic [1:0]            par_oe_n;
    logic [31:0]           prdata;
    logic                  slverr;
  } bpc_state_t;

  // synchroniser reset matches idle pin levels, so no false write or edge follows reset
  localparam bpc_pins_t PINS_IDLE = '{
    data:                    16'h0000,
    addr_hi:                 '0,
    mem_par_n:               2'b11,
    write_cycle_indicator_n: 1'b1,
    bus_master_sync:         1'b0,
    memory_slave_sync:       1'b0,
    bus_init:                1'b0
  };

  localparam bpc_state_t ST_RST = '{
    s1:         PINS_IDLE,
    s2:         PINS_IDLE,
    msync_prev: 1'b0,
    fsm:        BPC_IDLE,
    cnt:        '0,
    err_ff:     1'b0,
    inh_ff:     1'b0,
    control_status_word:        CSR_RST,
    par_out_n:  2'b11,
    par_oe_n:   2'b11,
    prdata:     32'h0000_0000,
    slverr:     1'b0
  };

  logic       rst_meta_ff;
  logic       rst_n_ff;
  bpc_state_t st_ff;
  bpc_state_t nxt_st;

  logic       writing;
  logic       msync_rise;
  logic       par_err;
  logic [1:0] odd;
  logic [8:0] tree_in;
  bpc_reg_t   sel;

  // ============================================================
  // functions
  function automatic logic bpc_odd(input logic [8:0] bits);
    return ^bits;
  endfunction

  function automatic bpc_reg_t bpc_decode(input logic [ADDR_W-1:0] addr);
    bpc_reg_t r;
    r = BPC_REG_NONE;
    if (addr == CSR_OFFSET) begin
      r = BPC_REG_CSR;
    end else if (addr == STATUS_OFFSET) begin
      r = BPC_REG_STATUS;
    end
    return r;
  endfunction

  // ============================================================
  // reset release
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // ============================================================
  // next state
  always_comb begin
    nxt_st     = st_ff;
    tree_in    = '0;
    odd        = '0;
    sel        = bpc_decode(APB_REQ.paddr);

    // two-flop synchronisers on all backplane inputs
    nxt_st.s1         = BUS_IN;
    nxt_st.s2         = st_ff.s1;
    nxt_st.msync_prev = st_ff.s2.bus_master_sync;

    writing    = ~st_ff.s2.write_cycle_indicator_n;
    msync_rise = st_ff.s2.bus_master_sync & ~st_ff.msync_prev;

    // parity trees, one per byte
    for (int i = 0; i < 2; i++) begin
      tree_in[7:0] = st_ff.s2.data[i*8 +: 8];
      if (writing) begin
        tree_in[8] = ~st_ff.control_status_word[CSR_WRONG_BIT];
      end else begin
        tree_in[8] = ~st_ff.s2.mem_par_n[i];
      end
      odd[i] = bpc_odd(tree_in);
    end
    par_err = ~writing & ~(&odd);

    // internal bus drivers only during writes
    nxt_st.par_out_n = ~odd;
    nxt_st.par_oe_n  = writing ? 2'b00 : 2'b11;

    // apb: read data captured in setup phase, writes at access
    if (APB_REQ.psel && !APB_REQ.penable) begin
      nxt_st.slverr = (sel == BPC_REG_NONE);
      unique case (sel)
        BPC_REG_CSR: begin
          nxt_st.prdata = {16'h0000, st_ff.control_status_word};
        end
        BPC_REG_STATUS: begin
          nxt_st.prdata = 32'h0000_0000;
          nxt_st.prdata[STS_ERR_FF_BIT]           = st_ff.err_ff;
          nxt_st.prdata[STS_INH_FF_BIT]           = st_ff.inh_ff;
          nxt_st.prdata[STS_FSM_LSB +: 4]         = st_ff.fsm;
          nxt_st.prdata[STS_PAR_ERR_BIT]          = par_err;
          nxt_st.prdata[STS_ODD_LSB +: 2]         = odd;
        end
        BPC_REG_NONE: begin
          nxt_st.prdata = 32'h0000_0000;
        end
      endcase
    end
    if (APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite && sel == BPC_REG_CSR) begin
      nxt_st.control_status_word = APB_REQ.pwdata[15:0] & CSR_WMASK;
    end

    // bus initialize clears enable, wrong-parity and error flag
    if (st_ff.s2.bus_init) begin
      nxt_st.control_status_word[CSR_ERR_EN_BIT]  = 1'b0;
      nxt_st.control_status_word[CSR_WRONG_BIT]   = 1'b0;
      nxt_st.control_status_word[CSR_PAR_ERR_BIT] = 1'b0;
    end

    // memory sync dropped: end of cycle cleanup
    if (!st_ff.s2.memory_slave_sync && st_ff.fsm != BPC_IDLE) begin
      nxt_st.fsm    = BPC_IDLE;
      nxt_st.err_ff = 1'b0;
      nxt_st.inh_ff = 1'b0;
    end else begin
      unique case (st_ff.fsm)
        BPC_IDLE: begin
          if (st_ff.s2.memory_slave_sync && !writing) begin
            nxt_st.fsm = BPC_SAMPLE;
            nxt_st.cnt = SAMPLE_CNT_INIT;
          end
        end
        BPC_SAMPLE: begin
          if (writing) begin
            nxt_st.fsm = BPC_IDLE;
          end else if (st_ff.cnt != '0) begin
            nxt_st.cnt = st_ff.cnt - CNT_W'(1);
          end else begin
            nxt_st.err_ff = par_err;
            nxt_st.inh_ff = par_err;
            if (par_err) begin
              nxt_st.fsm = BPC_ERR_PULSE;
              nxt_st.cnt = PULSE_CNT_INIT;
              nxt_st.control_status_word[CSR_PAR_ERR_BIT] = 1'b1;
              nxt_st.control_status_word[CSR_ADDR_LSB +: CSR_ADDR_W] = st_ff.s2.addr_hi;
            end else begin
              nxt_st.fsm = BPC_HOLD;
            end
          end
        end
        BPC_ERR_PULSE: begin
          if (st_ff.cnt != '0) begin
            nxt_st.cnt = st_ff.cnt - CNT_W'(1);
          end else begin
            nxt_st.inh_ff = 1'b0;
            nxt_st.fsm    = BPC_HOLD;
          end
        end
        BPC_HOLD: begin
          nxt_st.fsm = BPC_HOLD;
        end
        default: begin
          nxt_st.fsm = BPC_IDLE;
        end
      endcase
    end

    // master sync assertion blocks slave sync until released
    if (msync_rise) begin
      nxt_st.inh_ff = 1'b1;
    end
    // writes never wait on the inhibit
    if (writing) begin
      nxt_st.inh_ff = 1'b0;
    end
  end

  // ============================================================
  // state register
  always_ff @(posedge SYS_CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ============================================================
  // outputs
  always_comb begin
    APB_RSP.pready  = APB_REQ.psel & APB_REQ.penable;
    APB_RSP.prdata  = st_ff.prdata;
    APB_RSP.pslverr = st_ff.slverr & APB_REQ.psel & APB_REQ.penable;
  end

  assign BUS_SLAVE_SYNC   = st_ff.s2.memory_slave_sync & ~st_ff.inh_ff;
  assign BUS_PARITY_ERROR = st_ff.err_ff & st_ff.control_status_word[CSR_ERR_EN_BIT];
  assign ERROR_LED        = st_ff.control_status_word[CSR_PAR_ERR_BIT];
  assign MEM_PARITY_OUT_N = st_ff.par_out_n;
  assign MEM_PARITY_OE_N  = st_ff.par_oe_n;

endmodule
`default_nettype wire

// File: bench/bpc_top_asserts.sv
// checker: port-level timing and gating of the parity controller
`timescale 1ns/100ps
`default_nettype none
module bpc_top_asserts
  import bpc_pkg::*;
(
  input wire logic                  SYS_CLK,          // clock
  input wire logic                  NRST,             // reset
  input wire bpc_pkg::bpc_apb_req_t APB_REQ,          // apb in
  input wire bpc_pkg::bpc_apb_rsp_t APB_RSP,          // apb out
  input wire bpc_pkg::bpc_pins_t    BUS_IN,           // pins in
  input wire logic                  BUS_SLAVE_SYNC,   // slave sync
  input wire logic                  BUS_PARITY_ERROR, // error line
  input wire logic                  ERROR_LED,        // led
  input wire logic [1:0]            MEM_PARITY_OUT_N, // parity out
  input wire logic [1:0]            MEM_PARITY_OE_N   // parity enable
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // ============================================================
  // assertions
  chk_pready_zero_wait: assert property (APB_REQ.psel && APB_REQ.penable |-> APB_RSP.pready)
    else $error("pready missing in access phase");
  chk_oe_write_only: assert property (MEM_PARITY_OE_N != 2'b11 |->
    MEM_PARITY_OE_N == 2'b00 && !$past(BUS_IN.write_cycle_indicator_n, 3))
    else $error("parity driver on outside write");
  chk_sync_needs_mem: assert property (BUS_SLAVE_SYNC |-> $past(BUS_IN.memory_slave_sync, 2))
    else $error("slave sync without memory sync");
  chk_err_sets_flag: assert property ($rose(BUS_PARITY_ERROR) |-> ERROR_LED)
    else $error("error line without flag");
  chk_err_extra_delay: assert property ($rose(BUS_PARITY_ERROR) |-> ##1 $rose(BUS_SLAVE_SYNC))
    else $error("slave sync not one cycle after error");
  chk_no_write_sample: assert property ($rose(ERROR_LED) |->
    $past(BUS_IN.write_cycle_indicator_n, 3))
    else $error("error sampled in write");
  chk_sync_drop: assert property ($fell(BUS_IN.memory_slave_sync) |->
    ##3 (!BUS_SLAVE_SYNC && !BUS_PARITY_ERROR))
    else $error("slave sync or error not cleared");
  chk_write_pass: assert property ($rose(BUS_IN.memory_slave_sync) &&
    !BUS_IN.write_cycle_indicator_n && !$past(BUS_IN.write_cycle_indicator_n, 4)
    |-> ##[1:3] BUS_SLAVE_SYNC)
    else $error("write slave sync late");
  chk_read_answer: assert property ($rose(BUS_IN.memory_slave_sync) &&
    BUS_IN.write_cycle_indicator_n |-> ##[5:11] BUS_SLAVE_SYNC)
    else $error("read slave sync late");
endmodule
bind bpc_top bpc_top_asserts i_bpc_top_asserts (.SYS_CLK(SYS_CLK), .NRST(NRST),
  .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .BUS_IN(BUS_IN), .BUS_SLAVE_SYNC(BUS_SLAVE_SYNC),
  .BUS_PARITY_ERROR(BUS_PARITY_ERROR), .ERROR_LED(ERROR_LED),
  .MEM_PARITY_OUT_N(MEM_PARITY_OUT_N), .MEM_PARITY_OE_N(MEM_PARITY_OE_N));
`default_nettype wire

// File: bench/bpc_mem_model.sv
// behavioural parity memory module on the internal bus
`timescale 1ns/100ps
`default_nettype none
module bpc_mem_model (
  input wire logic        clk,       // clock
  input wire logic        wr_n,      // write indicator
  input wire logic        msync,     // master sync
  input wire logic [6:0]  addr,      // word index
  input wire logic [15:0] wdata,     // bus data
  input wire logic [1:0]  par_out_n, // generated parity
  input wire logic [3:0]  dly,       // answer delay
  output logic [15:0]     rdata,     // read data
  output logic [1:0]      par_n,     // stored parity
  output logic            sync,      // memory slave sync
  output logic            drv        // drives data
);
  logic [17:0] mem [128];
  initial begin
    sync = 1'b0;
    drv = 1'b0;
    rdata = 16'h0000;
    par_n = 2'b11;
    forever begin
      @(posedge clk);
      if (msync) begin
        if (!wr_n) begin
          repeat (dly) @(posedge clk);
          mem[addr] <= {par_out_n, wdata};
        end else begin
          drv <= 1'b1;
          {par_n, rdata} <= mem[addr];
          repeat (dly) @(posedge clk);
        end
        sync <= 1'b1;
        while (msync) @(posedge clk);
        sync <= 1'b0;
        drv <= 1'b0;
        rdata <= ~rdata;
        par_n <= ~par_n;
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/test_byte_parity_controller.sv
// testbench of the byte parity controller
`timescale 1ns/100ps
`default_nettype none
module test_byte_parity_controller;
  import bpc_pkg::*;
  logic SYS_CLK, NRST, bss, bpe, led, bpe_seen, wr_n, msync, init, m_sync, m_drv, e;
  logic [1:0] pout_n, poe_n, m_par_n, pseen;
  logic [15:0] d, m_data;
  logic [6:0] a;
  logic [3:0] dly;
  logic [31:0] q;
  int num_errors, cmp_count, lat, lat_clean;
  bpc_apb_req_t req;
  bpc_apb_rsp_t rsp;
  bpc_pins_t pins;
  assign pins = '{m_drv ? m_data : d, a, m_par_n, wr_n, msync, m_sync, init};
  bpc_top i_bpc_top (.SYS_CLK(SYS_CLK), .NRST(NRST), .APB_REQ(req), .APB_RSP(rsp),
    .BUS_IN(pins), .BUS_SLAVE_SYNC(bss), .BUS_PARITY_ERROR(bpe), .ERROR_LED(led),
    .MEM_PARITY_OUT_N(pout_n), .MEM_PARITY_OE_N(poe_n));
  bpc_mem_model i_bpc_mem_model (.clk(SYS_CLK), .wr_n(wr_n), .msync(msync), .addr(a),
    .wdata(d), .par_out_n(pout_n), .dly(dly), .rdata(m_data), .par_n(m_par_n),
    .sync(m_sync), .drv(m_drv));
  initial begin
    SYS_CLK = 1'b0;
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end
  always @(posedge SYS_CLK) if (bpe === 1'b1) bpe_seen <= 1'b1;
  // ============================================================
  // shared tasks
  task check(input string n, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, x, s);
    end
  endtask
  task end_of_test;
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    @(posedge SYS_CLK);
    req <= '{1'b1, 1'b0, w, ad, wd};
    @(posedge SYS_CLK);
    req.penable <= 1'b1;
    n = 0;
    do begin @(posedge SYS_CLK); n++; end while (rsp.pready !== 1'b1 && n < 50);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask
  task cycle(input logic w, input logic [6:0] ad, input logic [15:0] dat);
    int n;
    @(posedge SYS_CLK);
    {a, wr_n, d, msync, dly} <= {ad, ~w, dat, 1'b1, w ? 4'd8 : 4'd4};
    lat = 0;
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
      if (m_sync === 1'b1) lat++;
    end while (bss !== 1'b1 && n < 80);
    pseen = pout_n;
    check("par_oe", poe_n, w ? 2'b00 : 2'b11);
    msync <= 1'b0;
    n = 0;
    do begin @(posedge SYS_CLK); n++; end while (bss !== 1'b0 && n < 20);
    wr_n <= 1'b1;
    d <= ~d;
    repeat (4) @(posedge SYS_CLK);
  endtask
  // ============================================================
  // scenarios
  task t_reset;
    apb(1'b0, CSR_OFFSET, 32'h0);
    check("csr_rst", q, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    check("unmapped_err", 32'(e), 32'h1);
    check("unmapped", q, 32'h0);
  endtask
  task t_gen;
    logic [15:0] w [4];
    w = '{16'h0000, 16'hffff, 16'h0180, 16'h7f01};
    for (int i = 0; i < 4; i++) begin
      cycle(1'b1, 7'(i), w[i]);
      check("par_gen", pseen, {^w[i][15:8], ^w[i][7:0]});
      check("wr_lat", lat <= 3, 1'b1);
    end
    for (int i = 0; i < 4; i++) begin
      cycle(1'b0, 7'(i), 16'h0);
      check("clean", {led, bpe}, 2'b00);
      check("clean_lat", lat >= 6 && lat <= 10, 1'b1);
    end
    lat_clean = lat;
  endtask
  task t_wrong;
    apb(1'b1, CSR_OFFSET, 32'h5);
    cycle(1'b1, 7'h55, 16'h1234);
    check("par_wrong", pseen, {~^8'h12, ~^8'h34});
    check("led_wr", led, 1'b0);
    apb(1'b1, CSR_OFFSET, 32'h1);
    bpe_seen <= 1'b0;
    cycle(1'b0, 7'h55, 16'h0);
    check("err_lat", lat, lat_clean + PULSE_CYC);
    check("bpe_on", {bpe_seen, led}, 2'b11);
    apb(1'b0, CSR_OFFSET, 32'h0);
    check("csr_err", q, 32'h8001 | (32'h55 << CSR_ADDR_LSB));
    apb(1'b1, CSR_OFFSET, 32'h0);
    bpe_seen <= 1'b0;
    cycle(1'b0, 7'h55, 16'h0);
    check("bpe_off", {bpe_seen, led}, 2'b01);
    init <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    init <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    apb(1'b0, CSR_OFFSET, 32'h0);
    check("led_init", 32'(led), 32'h0);
    check("csr_init", q, 32'h55 << CSR_ADDR_LSB);
  endtask
  initial begin
    {NRST, wr_n, msync, init, bpe_seen, d, a, dly} = {4'b0100, 1'b0, 16'h0, 7'h0, 4'd4};
    req = '0;
    num_errors = 0;
    cmp_count = 0;
    repeat (8) @(posedge SYS_CLK);
    NRST <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    t_reset;
    t_gen;
    t_wrong;
    end_of_test;
  end
  initial begin
    #500000;
    num_errors++;
    end_of_test;
  end
endmodule
`default_nettype wire
